// [lcd_osc_irq_control_regs.sv]
// added special function register bank: gates, oscillator, display
// Summary of operation
// - every register in the bank is readable and writable by software
// - gate bit n blocks or permits the interrupt from port-0 line n
// - the misc control register supports single-bit set, clear, test
// - keep-alive bit 5 keeps the slow oscillator running in power-down
// - hardware sets the seconds flag bit 4 on 1-second overflow
// - software writes can set or clear the seconds flag
// - seconds flag high presents a 1-second interrupt request
// - level bits 3..0 choose active level of lines 4..7 for interrupt
// - level bit zero means low level interrupts, one means high level
// - trim register holds 5-bit code, reset 1, drives the oscillator
// - display control resets to 0x0C: off, third bias, 1:4
// - display enable zero forces all segment outputs low; backplane flags follow the mux bits
// - display enable one lets segment data be displayed
// - bias bit one selects half bias, zero third bias
// - mux bits encode static, 1:2, 1:3, 1:4
// - twelve 8-bit segment registers, reset zero, at two address groups
// - segment register bits 23..0 map one-to-one to the 24 segment outputs
// - two shared segment outputs become backplanes by mux ratio
module lcd_osc_irq_control_regs
  import sfr_bank_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [7:0]            sfr_addr_i,
  input  wire logic                  sfr_wr_i,
  input  wire logic [7:0]            sfr_wdata_i,
  input  wire logic                  sfr_rd_i,
  input  wire logic                  bit_wr_i,
  input  wire logic [2:0]            bit_sel_i,
  input  wire logic                  bit_val_i,
  input  wire logic                  second_overflow_i,
  input  wire logic [7:0]            port_i,
  output logic      [7:0]            sfr_rdata_o,
  output logic                       sfr_hit_o,
  output logic                       bit_rdata_o,
  output logic                       external_interrupt_zero_o,
  output logic                       seconds_irq_o,
  output logic                       slow_osc_keep_alive_o,
  output logic      [TRIM_W-1:0]     current_controlled_oscillator_o,
  output logic                       display_enable_o,
  output logic                       bias_half_o,
  output sfr_bank_pkg::mux_ratio_t   mux_ratio_o,
  output logic      [23:0]           segment_o,
  output logic                       shared_output_a_bp_o,
  output logic                       shared_output_b_bp_o
);
  import sfr_bank_pkg::*;

  typedef struct packed {
    logic [7:0]              gate;
    logic [7:0]              misc;
    logic [7:0]              trim;
    logic [7:0]              disp;
    logic [SEG_REGS*8-1:0]   seg;
    logic [7:0]              rdata;
    logic                    hit;
    logic                    bit_rdata;
    logic                    ext_irq;
    logic [23:0]             seg_out;
    logic [1:0]              bp_duty;
  } state_t;

  state_t s_q;
  state_t s_d;

  // decode and segment map assume two equal groups filling 96 bits
  if (SEG_REGS != 2 * SEG_GROUP_LEN || SEG_REGS * 8 != 96 || TRIM_W > 8)
  begin : g_size_check
    $error("segment or trim sizes do not fit the register map");
  end

  logic [7:0]  line_hit;
  logic [23:0] seg_next;
  logic [1:0]  bp_next;
  logic        in_lo;
  logic        in_hi;
  logic [3:0]  seg_idx;
  logic [7:0]  wmisc;
  logic [7:0]  rd_val;

  port_irq_gate u_gate (
    .port_i  (port_i),
    .gate_i  (s_q.gate),
    .level_i (s_q.misc[3:0]),
    .hit_o   (line_hit)
  );

  // waveform logic reads the next-state copy and its result is registered, keeping the outputs glitch free
  segment_map u_map (
    .seg_bits_i (s_d.seg),
    .enable_i   (s_d.disp[DISP_ENABLE]),
    .mux_i      (s_d.disp[DISP_MUX_HI:DISP_MUX_LO]),
    .seg_o      (seg_next),
    .bp_duty_o  (bp_next)
  );

  assign in_lo = (sfr_addr_i >= ADDR_SEG_LO) &&
                 (sfr_addr_i < ADDR_SEG_LO + 8'(SEG_GROUP_LEN));
  assign in_hi = (sfr_addr_i >= ADDR_SEG_HI) &&
                 (sfr_addr_i < ADDR_SEG_HI + 8'(SEG_GROUP_LEN));
  always_comb
  begin
    seg_idx = 4'h0;
    if (in_lo)
      seg_idx = 4'(sfr_addr_i - ADDR_SEG_LO);
    else if (in_hi)
      seg_idx = 4'(sfr_addr_i - ADDR_SEG_HI) + 4'(SEG_GROUP_LEN);
  end

  always_comb
  begin
    rd_val = 8'h00;
    case (sfr_addr_i)
      ADDR_GATE: rd_val = s_q.gate;
      ADDR_MISC: rd_val = s_q.misc;
      ADDR_TRIM: rd_val = s_q.trim;
      ADDR_DISP: rd_val = s_q.disp;
      default:
      begin
        if (in_lo || in_hi)
          rd_val = s_q.seg[seg_idx*8 +: 8];
      end
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    wmisc = s_q.misc;
    if (sfr_wr_i)
    begin
      case (sfr_addr_i)
        ADDR_GATE: s_d.gate = sfr_wdata_i;
        ADDR_MISC: wmisc = sfr_wdata_i;
        ADDR_TRIM: s_d.trim = sfr_wdata_i & MASK_TRIM;
        ADDR_DISP: s_d.disp = sfr_wdata_i & MASK_DISP;
        default:
        begin
          if (in_lo || in_hi)
            s_d.seg[seg_idx*8 +: 8] = sfr_wdata_i;
        end
      endcase
    end
    if (bit_wr_i && !sfr_wr_i)
      wmisc[bit_sel_i] = bit_val_i;
    if (second_overflow_i)
      wmisc[MISC_SECONDS] = 1'b1;
    s_d.misc = wmisc & MASK_MISC;
    s_d.hit = sfr_rd_i && ((sfr_addr_i == ADDR_GATE) ||
              (sfr_addr_i == ADDR_MISC) || (sfr_addr_i == ADDR_TRIM) ||
              (sfr_addr_i == ADDR_DISP) || in_lo || in_hi);
    s_d.rdata = sfr_rd_i ? rd_val : 8'h00;
    s_d.bit_rdata = s_q.misc[bit_sel_i];
    // any gated line raises interrupt zero
    s_d.ext_irq = |line_hit;
    s_d.seg_out = seg_next;
    s_d.bp_duty = bp_next;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_q.gate      <= RST_GATE;
      s_q.misc      <= RST_MISC;
      s_q.trim      <= RST_TRIM;
      s_q.disp      <= RST_DISP;
      s_q.seg       <= {SEG_REGS{RST_SEG}};
      s_q.rdata     <= 8'h00;
      s_q.hit       <= 1'b0;
      s_q.bit_rdata <= 1'b0;
      s_q.ext_irq   <= 1'b0;
      s_q.seg_out   <= 24'h000000;
      s_q.bp_duty   <= 2'b11;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_o                     = s_q.rdata;
  assign sfr_hit_o                       = s_q.hit;
  assign bit_rdata_o                     = s_q.bit_rdata;
  assign external_interrupt_zero_o       = s_q.ext_irq;
  assign seconds_irq_o                   = s_q.misc[MISC_SECONDS];
  assign slow_osc_keep_alive_o           = s_q.misc[MISC_KEEP_ALIVE];
  assign current_controlled_oscillator_o = s_q.trim[TRIM_W-1:0];
  assign display_enable_o                = s_q.disp[DISP_ENABLE];
  assign bias_half_o                     = s_q.disp[DISP_BIAS];
  assign mux_ratio_o = mux_ratio_t'(s_q.disp[DISP_MUX_HI:DISP_MUX_LO]);
  assign segment_o                       = s_q.seg_out;
  assign shared_output_a_bp_o            = s_q.bp_duty[0];
  assign shared_output_b_bp_o            = s_q.bp_duty[1];

  seconds_req_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    second_overflow_i |=> seconds_irq_o)
    else $error("overflow did not raise seconds request");

  // flag holds without a clearing write
  seconds_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (seconds_irq_o && !sfr_wr_i && !bit_wr_i) |=> seconds_irq_o)
    else $error("seconds flag dropped without a write");

  disabled_low_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !display_enable_o |-> segment_o == 24'h000000)
    else $error("segments driven while display disabled");

  trim_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_wr_i && sfr_addr_i == ADDR_TRIM) |=>
      current_controlled_oscillator_o == $past(sfr_wdata_i[4:0]))
    else $error("trim code not taken");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    s_q.misc[7:6] == 2'b00 && s_q.trim[7:5] == 3'b000 &&
    s_q.disp[7:4] == 4'h0)
    else $error("reserved bit set");

  mux_backplane_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mux_ratio_o == MUX_1_4 |-> shared_output_a_bp_o && shared_output_b_bp_o)
    else $error("shared outputs not backplanes in 1:4");

  gate_block_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s_q.gate == 8'h00) |=> !external_interrupt_zero_o)
    else $error("interrupt with all gates closed");

  level_high_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s_q.gate[4] && s_q.misc[0] && port_i[4]) |=> external_interrupt_zero_o)
    else $error("high level on line 4 not detected");

  bit_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (bit_wr_i && !sfr_wr_i && !second_overflow_i && bit_sel_i < 3'd6) |=>
      s_q.misc[$past(bit_sel_i)] == $past(bit_val_i))
    else $error("bit write lost");

  keep_alive_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_wr_i && sfr_addr_i == ADDR_MISC) |=>
      slow_osc_keep_alive_o == $past(sfr_wdata_i[MISC_KEEP_ALIVE]))
    else $error("keep-alive bit not taken");

  seconds_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_wr_i && sfr_addr_i == ADDR_MISC && !second_overflow_i) |=>
      seconds_irq_o == $past(sfr_wdata_i[MISC_SECONDS]))
    else $error("seconds flag write not taken");

  gate_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_wr_i && sfr_addr_i == ADDR_GATE) |=> s_q.gate == $past(sfr_wdata_i))
    else $error("gate register write lost");

  trim_read_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_rd_i && sfr_addr_i == ADDR_TRIM) |=> sfr_hit_o &&
      sfr_rdata_o == {3'b000, $past(current_controlled_oscillator_o)})
    else $error("trim read returned wrong data");

  // no read leaves the bus quiet
  idle_read_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !sfr_rd_i |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("read data without a read");

  low_line_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s_q.gate[0] && !port_i[0]) |=> external_interrupt_zero_o)
    else $error("low level on line 0 not detected");

  level_low_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (s_q.gate[5] && !s_q.misc[1] && !port_i[5]) |=>
      external_interrupt_zero_o)
    else $error("low level on line 5 not detected");

  enable_show_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (display_enable_o && mux_ratio_o == MUX_STATIC) |->
      segment_o == s_q.seg[23:0])
    else $error("segment data not shown in static mode");

  // low ratios keep shared outputs as segments
  shared_seg_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (mux_ratio_o == MUX_STATIC || mux_ratio_o == MUX_1_2) |->
      !shared_output_a_bp_o && !shared_output_b_bp_o)
    else $error("shared output taken below 1:3");

  // 1:3 takes only one shared output
  shared_third_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    mux_ratio_o == MUX_1_3 |->
      !shared_output_a_bp_o && shared_output_b_bp_o)
    else $error("shared outputs wrong in 1:3");

  disp_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (sfr_wr_i && sfr_addr_i == ADDR_DISP) |=>
      bias_half_o == $past(sfr_wdata_i[DISP_BIAS]) &&
      mux_ratio_o == $past(sfr_wdata_i[DISP_MUX_HI:DISP_MUX_LO]))
    else $error("display control bits not taken");
endmodule

// [sfr_bank_pkg.sv]
// constants for the added special function register bank
package sfr_bank_pkg;
  localparam logic [7:0] ADDR_GATE     = 8'h97;
  localparam logic [7:0] ADDR_MISC     = 8'h98;
  localparam logic [7:0] ADDR_SEG_LO   = 8'h9A;
  localparam logic [7:0] ADDR_TRIM     = 8'hB7;
  localparam logic [7:0] ADDR_DISP     = 8'hB9;
  localparam logic [7:0] ADDR_SEG_HI   = 8'hBA;
  localparam int         SEG_GROUP_LEN = 6;
  localparam int         SEG_REGS      = 12;

  localparam logic [7:0] RST_GATE = 8'h00;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h01;
  localparam logic [7:0] RST_DISP = 8'h0C;
  localparam logic [7:0] RST_SEG  = 8'h00;

  localparam logic [7:0] MASK_MISC = 8'h3F;
  localparam logic [7:0] MASK_TRIM = 8'h1F;
  localparam logic [7:0] MASK_DISP = 8'h0F;

  localparam int MISC_KEEP_ALIVE = 5;
  localparam int MISC_SECONDS    = 4;
  localparam int DISP_ENABLE     = 0;
  localparam int DISP_BIAS       = 1;
  localparam int DISP_MUX_LO     = 2;
  localparam int DISP_MUX_HI     = 3;
  localparam int TRIM_W          = 5;

  typedef enum logic [1:0] {
    MUX_STATIC = 2'b00,
    MUX_1_2    = 2'b01,
    MUX_1_3    = 2'b10,
    MUX_1_4    = 2'b11
  } mux_ratio_t;
endpackage

// [port_irq_gate.sv]
// gated level detection of port-0 lines onto external interrupt zero
module port_irq_gate
  import sfr_bank_pkg::*;
(
  input  wire logic [7:0] port_i,
  input  wire logic [7:0] gate_i,
  input  wire logic [3:0] level_i,
  output logic      [7:0] hit_o
);
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_line
      if (g < 4)
      begin : g_low
        assign hit_o[g] = gate_i[g] & ~port_i[g];
      end
      else
      begin : g_sel
        assign hit_o[g] = gate_i[g] & ~(port_i[g] ^ level_i[g-4]);
      end
    end
  endgenerate
endmodule

// [segment_map.sv]
// segment data routing and backplane takeover of shared outputs
module segment_map
  import sfr_bank_pkg::*;
(
  input  wire logic [95:0] seg_bits_i,
  input  wire logic        enable_i,
  input  wire logic [1:0]  mux_i,
  output logic      [23:0] seg_o,
  output logic      [1:0]  bp_duty_o
);
  logic [23:0] row;
  // only the first backplane row is routed; no time slicing is done, and
  // the rows in the other segment registers never reach the outputs
  assign row = seg_bits_i[23:0];
  assign bp_duty_o[1] = (mux_i == MUX_1_3) || (mux_i == MUX_1_4);
  assign bp_duty_o[0] = (mux_i == MUX_1_4);
  always_comb
  begin
    seg_o = '0;
    if (enable_i)
    begin
      seg_o = row;
      if (bp_duty_o[0])
        seg_o[22] = 1'b0;
      if (bp_duty_o[1])
        seg_o[23] = 1'b0;
    end
  end
endmodule

// [lcd_osc_irq_control_regs_test.sv]
// self-checking bench for the added special function register bank
module lcd_osc_irq_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sfr_bank_pkg::*;

  logic        clk_i, reset_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_val_i;
  logic        second_overflow_i, sfr_hit_o, bit_rdata_o, seconds_irq_o;
  logic        external_interrupt_zero_o, slow_osc_keep_alive_o;
  logic        display_enable_o, bias_half_o;
  logic        shared_output_a_bp_o, shared_output_b_bp_o;
  logic [2:0]  bit_sel_i;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, port_i, sfr_rdata_o;
  logic [4:0]  current_controlled_oscillator_o;
  logic [23:0] segment_o;
  mux_ratio_t  mux_ratio_o;
  int          mismatches, n_tests, lv, n, m;
  logic        act;
  logic [7:0]  lvl;

  lcd_osc_irq_control_regs i_dut (
    .clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
    .bit_wr_i, .bit_sel_i, .bit_val_i, .second_overflow_i, .port_i,
    .sfr_rdata_o, .sfr_hit_o, .bit_rdata_o, .external_interrupt_zero_o,
    .seconds_irq_o, .slow_osc_keep_alive_o, .current_controlled_oscillator_o,
    .display_enable_o, .bias_half_o, .mux_ratio_o, .segment_o,
    .shared_output_a_bp_o, .shared_output_b_bp_o
  );

  always #12.5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    chk(sfr_rdata_o, e);
    chk(sfr_hit_o, h);
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge clk_i);
    bit_wr_i <= 1'b1;
    bit_sel_i <= s;
    bit_val_i <= v;
    @(posedge clk_i);
    bit_wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(bit_rdata_o, v);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // expected segment word for mux ratio mm and enable en
  function automatic logic [23:0] seg_exp(input int mm, input logic en);
    logic [23:0] w;
    w = en ? 24'hE2D1C0 : 24'h000000;
    if (mm == 3) w[22] = 1'b0;
    if (mm >= 2) w[23] = 1'b0;
    return w;
  endfunction

  // address of segment register i in its group
  function automatic logic [7:0] seg_addr(input int i);
    if (i < SEG_GROUP_LEN)
      return ADDR_SEG_LO + 8'(i);
    return ADDR_SEG_HI + 8'(i - SEG_GROUP_LEN);
  endfunction

  // distinct data pattern for segment register i
  function automatic logic [7:0] seg_val(input int i);
    return 8'(8'hC0 + 8'h11 * i);
  endfunction

  initial
  begin
    #(3000 * 25);
    mismatches++;
    conclude();
  end

  initial
  begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    bit_wr_i = 1'b0;
    bit_val_i = 1'b0;
    bit_sel_i = 3'h0;
    second_overflow_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    port_i = 8'hFF;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // reset state of registers and outputs
    rd(8'h97, 8'h00, 1'b1);
    rd(8'h98, 8'h00, 1'b1);
    rd(8'hB7, 8'h01, 1'b1);
    rd(8'hB9, 8'h0C, 1'b1);
    chk(mux_ratio_o, MUX_1_4);
    chk({display_enable_o, bias_half_o, segment_o}, 26'h0);
    chk(current_controlled_oscillator_o, 5'h01);
    for (n = 0; n < 12; n++)
      rd(seg_addr(n), 8'h00, 1'b1);
    // unmapped place refuses, mapped places keep data
    wr(8'h99, 8'hFF);
    rd(8'h99, 8'h00, 1'b0);
    for (n = 0; n < 12; n++)
      wr(seg_addr(n), seg_val(n));
    for (n = 0; n < 12; n++)
      rd(seg_addr(n), seg_val(n), 1'b1);
    wr(8'hB7, 8'hF5);
    chk(current_controlled_oscillator_o, 5'h15);
    rd(8'hB7, 8'h15, 1'b1);
    wr(8'hB9, 8'hF2);
    rd(8'hB9, 8'h02, 1'b1);
    chk({bias_half_o, segment_o}, 25'h1000000);
    for (m = 0; m < 4; m++)
    begin
      wr(8'hB9, 8'(8'h01 | (m << 2)));
      chk(mux_ratio_o, m);
      chk(segment_o, seg_exp(m, 1'b1));
      chk(shared_output_a_bp_o, m == 3);
      chk(shared_output_b_bp_o, m >= 2);
      chk({display_enable_o, bias_half_o}, 2'b10);
    end
    wr(8'hB9, 8'h04);
    chk(segment_o, 24'h0);
    // seconds flag set, held, cleared, set
    wr(8'h98, 8'hE0);
    rd(8'h98, 8'h20, 1'b1);
    chk({slow_osc_keep_alive_o, seconds_irq_o}, 2'b10);
    @(posedge clk_i);
    second_overflow_i <= 1'b1;
    @(posedge clk_i);
    second_overflow_i <= 1'b0;
    tick(20);
    chk(seconds_irq_o, 1'b1);
    rd(8'h98, 8'h30, 1'b1);
    wr(8'h98, 8'h00);
    chk({slow_osc_keep_alive_o, seconds_irq_o}, 2'b00);
    wr(8'h98, 8'h10);
    chk(seconds_irq_o, 1'b1);
    bw(3'h4, 1'b0);
    chk(seconds_irq_o, 1'b0);
    bw(3'h5, 1'b1);
    chk(slow_osc_keep_alive_o, 1'b1);
    // overflow and a clearing write in one cycle: the set wins
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= 8'h98;
    sfr_wdata_i <= 8'h00;
    second_overflow_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    second_overflow_i <= 1'b0;
    #1;
    chk(seconds_irq_o, 1'b1);
    chk(slow_osc_keep_alive_o, 1'b0);
    // byte write wins over a bit write in the same cycle
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= 8'h00;
    bit_wr_i <= 1'b1;
    bit_sel_i <= 3'h5;
    bit_val_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    bit_wr_i <= 1'b0;
    #1;
    chk(slow_osc_keep_alive_o, 1'b0);
    chk(seconds_irq_o, 1'b0);
    // gated level detection per line, two level patterns
    for (lv = 0; lv < 2; lv++)
    begin
      lvl = lv ? 8'h0A : 8'h05;
      wr(8'h98, lvl);
      for (n = 0; n < 8; n++)
      begin
        if (n < 4)
          act = 1'b0;
        else
          act = lvl[n - 4];
        wr(8'h97, 8'(1 << n));
        @(posedge clk_i);
        port_i <= {8{~act}};
        tick(2);
        chk(external_interrupt_zero_o, 1'b0);
        @(posedge clk_i);
        port_i[n] <= act;
        tick(2);
        chk(external_interrupt_zero_o, 1'b1);
        wr(8'h97, 8'h00);
        tick(2);
        chk(external_interrupt_zero_o, 1'b0);
      end
    end
    // a reset in mid-run restores the reset values
    wr(8'hB9, 8'h07);
    chk(bias_half_o, 1'b1);
    chk(segment_o, seg_exp(1, 1'b1));
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    tick(2);
    chk({display_enable_o, segment_o}, 25'h0);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'hB9, 8'h0C, 1'b1);
    rd(8'h97, 8'h00, 1'b1);
    rd(8'h9A, 8'h00, 1'b1);
    chk({shared_output_a_bp_o, shared_output_b_bp_o}, 2'b11);
    chk(bias_half_o, 1'b0);
    conclude();
  end
endmodule
